/* File: pkg/acsm_pkg.sv */
// Constants, register map and carrier types for the audio clock source and mode control
package acsm_pkg;
  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int LOCK_BASE_MS = 20;
  localparam int WCLK_LOCK_MS = 35;
  localparam int LOCK_BASE_CYC = LOCK_BASE_MS * 1000 * CLK_MHZ;
  // Word clock lock must finish inside 35 ms, so the settle time is the whole budget less 1 ms
  localparam int WCLK_LOCK_CYC = (WCLK_LOCK_MS - 1) * 1000 * CLK_MHZ;
  localparam logic [8:0] SLOW_LOCK_FRAMES = 9'h180;
  localparam logic [8:0] FAST_LOCK_FRAMES = 9'h001;
  localparam logic [8:0] WCLK_LOCK_FRAMES = 9'h000;
  localparam logic [13:0] IVL_MIN = 14'h0100;
  localparam logic [13:0] IVL_MAX = 14'h1400;
  localparam logic [13:0] XTAL_FRAME_CYC = 14'h0823;
  // Frame period midpoints between neighbouring standard rates, in clock cycles
  localparam logic [13:0] RATE_THR [9] = '{14'h10FF, 14'h0E3E, 14'h0A89, 14'h0880,
    14'h071F, 14'h0545, 14'h0440, 14'h0325, 14'h0220};
  localparam int GEN_SHIFT [3] = '{1, 7, 9};
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam int LOSS_SEEN_BIT = 16;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam logic [1:0] CM_PLL = 2'h0;
  localparam logic [1:0] CM_XTAL = 2'h1;
  localparam logic [1:0] CM_AUTO = 2'h2;
  localparam logic [1:0] CM_MONITOR = 2'h3;
  localparam logic [1:0] XTAL_UNUSED = 2'h3;

  typedef struct packed {
    logic [5:0] rsvd_hi;
    logic [1:0] xtal_freq_sel;
    logic rsvd_mid;
    logic wordclk_sync;
    logic tx_mclk_sel;
    logic mode_a;
    logic [1:0] clock_mode_sel;
    logic fast_lock;
    logic ref_sel;
  } acsm_ctrl_type;

  localparam acsm_ctrl_type CTRL_RESET = '0;

  typedef struct packed {
    logic [3:0] rate_code;
    logic rate_valid;
    logic tx_mclk_ext;
    logic clk_src_xtal;
    logic xtal_run;
    logic pll_run;
    logic eff_ref;
    logic unlock;
  } acsm_stat_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SETTLE = 3'b010,
    ST_LOCK = 3'b100
  } acsm_lock_type;
endpackage

/* File: logic/acsm_top.sv */
// Clock source, lock tracking and serial output selection with AXI4-Lite registers
`timescale 1ns/100ps
// Behaviour
// - Reference 0 biphase, 1 word clock
// - Reference is register bit OR strap
// - Biphase lock 20ms plus 384 or 1 frames
// - Word clock lock within 35ms always
// - Parallel strap forces fast lock
// - Wrong sync interval means unlock
// - Detect standard rate from clock or status
// - Word clock lock generates all clocks
// - Mode bit selects sync or mode_a
// - Mode 0 PLL/rx, mode 1 crystal/aux
// - Mode 2 falls back on unlock
// - Mode 3 crystal/aux, PLL keeps running
// - Modes 4-6 word clock, output aux
// - Crystal off in mode 0 only when unused
// - Mode_a output low in crystal cases
// - Mode_a tx clock crystal or external
// - Crystal off forces external tx clock in mode_a
// - Mode_a tx uses external clocks
module acsm_top #(
  parameter int LOCK_BASE_CYCLES = acsm_pkg::LOCK_BASE_CYC,
  parameter int WCLK_LOCK_CYCLES = acsm_pkg::WCLK_LOCK_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ref_sel_pin,
  input wire logic parallel_pin,
  input wire logic ext_frame_clk,
  input wire logic ext_bit_clk,
  input wire logic aux_data_in,
  input wire logic rx_sync_pulse,
  input wire logic rx_data,
  input wire logic [3:0] cs_rate_code,
  input wire logic cs_rate_valid,
  output logic serial_data_out,
  output logic master_clk_outputs,
  output logic bit_clk,
  output logic frame_clk,
  output logic pll_run,
  output logic xtal_run,
  output logic clk_src_xtal,
  output logic tx_mclk_ext,
  output logic tx_ext_clocks,
  output logic unlock
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [4:0] pin_raw;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic frame_prev_q;
  logic bitclk_prev_q;
  assign pin_raw = {aux_data_in, ext_bit_clk, ext_frame_clk, parallel_pin, ref_sel_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        pin_s1_q[gi] <= sys_rst ? 1'b0 : pin_raw[gi];
        pin_s2_q[gi] <= sys_rst ? 1'b0 : pin_s1_q[gi];
      end
    end
  endgenerate
  wire ref_pin_s = pin_s2_q[0];
  wire par_pin_s = pin_s2_q[1];
  wire frame_s = pin_s2_q[2];
  wire bitclk_s = pin_s2_q[3];
  wire aux_s = pin_s2_q[4];
  wire frame_rise = frame_s && !frame_prev_q;
  wire bitclk_rise = bitclk_s && !bitclk_prev_q;

  // ************************************************************
  // Registers and AXI4-Lite slave
  // ************************************************************
  acsm_pkg::acsm_ctrl_type ctrl_q;
  acsm_pkg::acsm_stat_type stat;
  logic loss_seen_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire aw_have = aw_hold_q || aw_take;
  wire w_have = w_hold_q || w_take;
  wire wr_fire = aw_have && w_have && !bvalid_q;
  wire [3:0] wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;
  wire wr_ctrl = wr_fire && wr_addr == acsm_pkg::CTRL_OFS;
  wire wr_stat = wr_fire && wr_addr == acsm_pkg::STATUS_OFS;
  wire wr_bad = wr_fire && !wr_ctrl && !wr_stat;
  wire [15:0] ctrl_bits = ctrl_q;
  wire [15:0] ctrl_new = {wr_strb[1] ? wr_data[15:8] : ctrl_bits[15:8],
    wr_strb[0] ? wr_data[7:0] : ctrl_bits[7:0]};
  wire loss_clr = wr_stat && wr_strb[2] && wr_data[acsm_pkg::LOSS_SEEN_BIT];
  wire rd_ctrl = s_axi_araddr == acsm_pkg::CTRL_OFS;
  wire rd_stat = s_axi_araddr == acsm_pkg::STATUS_OFS;
  wire [31:0] rd_word = rd_ctrl ? {16'h0000, ctrl_bits & 16'h037F} :
    rd_stat ? {15'h0000, loss_seen_q, 5'h00, stat} : 32'h0000_0000;
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= acsm_pkg::AXI_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_hold_q <= aw_have && !wr_fire;
      w_hold_q <= w_have && !wr_fire;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_bad ? acsm_pkg::AXI_SLVERR : acsm_pkg::AXI_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= acsm_pkg::AXI_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= (rd_ctrl || rd_stat) ? acsm_pkg::AXI_OKAY : acsm_pkg::AXI_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= acsm_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= acsm_pkg::acsm_ctrl_type'(ctrl_new & 16'h037F);
    end
  end

  // ************************************************************
  // Mode decode
  // ************************************************************
  wire eff_ref = ctrl_q.ref_sel || ref_pin_s;
  wire eff_fast = ctrl_q.fast_lock || par_pin_s;
  wire [1:0] cm = ctrl_q.clock_mode_sel;
  // Mode_a operation is only defined with the biphase reference
  wire mode_a_on = ctrl_q.mode_a && !eff_ref;
  wire xtal_unused = ctrl_q.xtal_freq_sel == acsm_pkg::XTAL_UNUSED;
  assign pll_run = cm != acsm_pkg::CM_XTAL;
  assign xtal_run = !(cm == acsm_pkg::CM_PLL && xtal_unused);
  // Ref 1 with mode 3 is undefined; treated like the crystal mode
  assign clk_src_xtal = cm == acsm_pkg::CM_XTAL || cm == acsm_pkg::CM_MONITOR ||
    (cm == acsm_pkg::CM_AUTO && unlock);
  wire out_rx = !eff_ref && !clk_src_xtal;
  assign tx_mclk_ext = mode_a_on && (ctrl_q.tx_mclk_sel || !xtal_run);
  assign tx_ext_clocks = mode_a_on;

  // ************************************************************
  // Lock tracking
  // ************************************************************
  acsm_pkg::acsm_lock_type lock_q;
  logic [13:0] ivl_q, prev_q;
  logic [21:0] settle_q;
  logic [8:0] frames_q;
  logic ref_prev_q;
  wire ref_evt = eff_ref ? frame_rise : rx_sync_pulse;
  wire [13:0] ivl_diff = ivl_q > prev_q ? ivl_q - prev_q : prev_q - ivl_q;
  wire ivl_ok = ivl_diff <= (prev_q >> 4) && ivl_q >= acsm_pkg::IVL_MIN;
  wire ivl_timeout = ivl_q == acsm_pkg::IVL_MAX;
  wire lock_bad = (ref_evt && !ivl_ok) || ivl_timeout || !pll_run ||
    eff_ref != ref_prev_q;
  wire good_evt = ref_evt && ivl_ok;
  wire [21:0] settle_need = eff_ref ? 22'(WCLK_LOCK_CYCLES) : 22'(LOCK_BASE_CYCLES);
  wire [8:0] frames_need = eff_ref ? acsm_pkg::WCLK_LOCK_FRAMES :
    eff_fast ? acsm_pkg::FAST_LOCK_FRAMES : acsm_pkg::SLOW_LOCK_FRAMES;
  wire settle_done = settle_q >= settle_need;
  assign unlock = lock_q != acsm_pkg::ST_LOCK;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ivl_q <= 14'h0000;
      prev_q <= 14'h0000;
      ref_prev_q <= 1'b0;
      frame_prev_q <= 1'b0;
      bitclk_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= eff_ref;
      frame_prev_q <= frame_s;
      bitclk_prev_q <= bitclk_s;
      if (ref_evt) begin
        ivl_q <= 14'h0001;
        prev_q <= ivl_q;
      end else if (!ivl_timeout) begin
        ivl_q <= ivl_q + 14'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_q <= acsm_pkg::ST_IDLE;
      settle_q <= 22'h000000;
      frames_q <= 9'h000;
    end else begin
      unique case (lock_q)
        acsm_pkg::ST_IDLE: begin
          settle_q <= 22'h000000;
          frames_q <= 9'h000;
          if (good_evt && !lock_bad) begin
            lock_q <= acsm_pkg::ST_SETTLE;
          end
        end
        acsm_pkg::ST_SETTLE: begin
          if (lock_bad) begin
            lock_q <= acsm_pkg::ST_IDLE;
          end else if (settle_done && frames_q >= frames_need) begin
            lock_q <= acsm_pkg::ST_LOCK;
          end else if (!settle_done) begin
            settle_q <= settle_q + 22'h000001;
          end else if (good_evt) begin
            frames_q <= frames_q + 9'h001;
          end
        end
        acsm_pkg::ST_LOCK: begin
          if (lock_bad) begin
            lock_q <= acsm_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Loss of lock is sticky; a new loss in the clearing cycle wins
  wire loss_evt = lock_q == acsm_pkg::ST_LOCK && lock_bad;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loss_seen_q <= 1'b0;
    end else begin
      loss_seen_q <= loss_evt || (loss_seen_q && !loss_clr);
    end
  end

  // ************************************************************
  // Rate detection
  // ************************************************************
  function automatic logic [3:0] rate_of(input logic [13:0] period);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 9; i++) begin
      if (period <= acsm_pkg::RATE_THR[i]) begin
        idx = idx + 4'h1;
      end
    end
    return idx;
  endfunction
  // System clock stands in for the crystal as the comparison clock
  wire [3:0] rate_meas = rate_of(prev_q);
  assign stat.rate_code = xtal_unused ? cs_rate_code : rate_meas;
  assign stat.rate_valid = xtal_unused ? cs_rate_valid : !unlock;
  assign stat.tx_mclk_ext = tx_mclk_ext;
  assign stat.clk_src_xtal = clk_src_xtal;
  assign stat.xtal_run = xtal_run;
  assign stat.pll_run = pll_run;
  assign stat.eff_ref = eff_ref;
  assign stat.unlock = unlock;

  // ************************************************************
  // Clock generation
  // ************************************************************
  // Recovered period while on the PLL, nominal crystal frame otherwise
  wire [13:0] gen_period = clk_src_xtal ? acsm_pkg::XTAL_FRAME_CYC : prev_q;
  wire gen_resync = !clk_src_xtal && ref_evt;
  logic [2:0] gen_q;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_div
      logic [13:0] cnt_q;
      wire [13:0] half_raw = gen_period >> acsm_pkg::GEN_SHIFT[gi];
      wire [13:0] half = half_raw == 14'h0000 ? 14'h0001 : half_raw;
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cnt_q <= 14'h0000;
          gen_q[gi] <= 1'b0;
        end else if (gen_resync) begin
          cnt_q <= 14'h0001;
          gen_q[gi] <= 1'b1;
        end else if (cnt_q >= half) begin
          cnt_q <= 14'h0001;
          gen_q[gi] <= !gen_q[gi];
        end else begin
          cnt_q <= cnt_q + 14'h0001;
        end
      end
    end
  endgenerate
  assign frame_clk = gen_q[0];
  assign bit_clk = gen_q[1];
  assign master_clk_outputs = gen_q[2];

  // ************************************************************
  // Serial data output
  // ************************************************************
  logic aux_q, sdo_q;
  // Mode_a aux data is taken on the external bit clock rising edge
  wire aux_take = mode_a_on ? bitclk_rise : 1'b1;
  wire sdo_d = out_rx ? rx_data : (mode_a_on ? 1'b0 : aux_q);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      if (aux_take) begin
        aux_q <= aux_s;
      end
      sdo_q <= sdo_d;
    end
  end
  assign serial_data_out = sdo_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_bad_evt;
    lock_q == acsm_pkg::ST_LOCK && lock_bad;
  endsequence
  a_unlock_on_bad: assert property (@(posedge clk) disable iff (sys_rst)
    s_bad_evt |=> unlock ##0 loss_seen_q)
    else $error("bad interval did not drop lock");
  a_ref_or_strap: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_q.ref_sel || ref_pin_s) == stat.eff_ref)
    else $error("reference select not ORed");
  a_fast_strap: assert property (@(posedge clk) disable iff (sys_rst)
    par_pin_s && !eff_ref |-> frames_need == acsm_pkg::FAST_LOCK_FRAMES)
    else $error("parallel strap did not force fast lock");
  a_lock_needs_settle: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(lock_q == acsm_pkg::ST_LOCK) |-> $past(settle_done))
    else $error("lock declared before settle time");
  a_mode2_fallback: assert property (@(posedge clk) disable iff (sys_rst)
    cm == acsm_pkg::CM_AUTO |-> clk_src_xtal == unlock)
    else $error("mode 2 source does not follow unlock");
  a_xtal_off: assert property (@(posedge clk) disable iff (sys_rst)
    !xtal_run |-> cm == acsm_pkg::CM_PLL && xtal_unused)
    else $error("crystal stopped outside PLL mode");
  a_pll_stop: assert property (@(posedge clk) disable iff (sys_rst)
    cm == acsm_pkg::CM_XTAL |=> unlock)
    else $error("stopped PLL still locked");
  a_mode_a_low: assert property (@(posedge clk) disable iff (sys_rst)
    mode_a_on && clk_src_xtal ##1 mode_a_on && clk_src_xtal |-> !serial_data_out)
    else $error("mode_a output not low");
  a_wclk_aux: assert property (@(posedge clk) disable iff (sys_rst)
    eff_ref ##1 eff_ref |-> serial_data_out == $past(aux_q))
    else $error("word clock mode not outputting aux");
  a_tx_ext_only: assert property (@(posedge clk) disable iff (sys_rst)
    mode_a_on && !xtal_run |-> tx_mclk_ext)
    else $error("crystal off but tx not on external clock");
endmodule

/* File: verif/acsm_src_model.sv */
// Far-side audio source: biphase sync pulses, word clock, bit clock and aux data
`timescale 1ns/100ps
// ********************
// Source model
// ********************
module acsm_src_model (
  input wire logic clk,
  input wire logic [13:0] period,
  input wire logic wclk_en,
  input wire logic drop,
  input wire logic aux_val,
  output logic ext_frame_clk,
  output logic ext_bit_clk,
  output logic aux_data_in,
  output logic rx_sync_pulse,
  output logic rx_data
);
  logic [13:0] cnt_q = 14'h0000;
  logic [15:0] lfsr_q = 16'hACE1;

  // Phase offset keeps the 80 ns bit clock unrelated to the system clock
  initial begin
    ext_bit_clk = 1'b0;
    #3;
    forever #40 ext_bit_clk = ~ext_bit_clk;
  end

  // Aux changes on the falling bit clock edge, stable at the rising one
  always @(negedge ext_bit_clk) aux_data_in <= aux_val;

  always @(posedge clk) begin
    cnt_q <= (cnt_q >= period - 14'h0001) ? 14'h0000 : cnt_q + 14'h0001;
    lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end

  // Drop models a broken stream: sync patterns missing, word clock stalled
  assign rx_sync_pulse = (cnt_q == 14'h0000) && !drop && !wclk_en;
  assign ext_frame_clk = wclk_en && !drop && (cnt_q < {1'b0, period[13:1]});
  assign rx_data = lfsr_q[0];
endmodule

/* File: verif/acsm_bench.sv */
// Self-checking bench for the audio clock source and mode control
`timescale 1ns/100ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module audio_clock_source_mode_control_bench;
  // Frame period near 96 kHz, well away from the crystal frame period
  localparam int P = 1042;
  localparam logic [3:0] CT = acsm_pkg::CTRL_OFS;
  localparam logic [3:0] ST = acsm_pkg::STATUS_OFS;
  logic clk = 1'b0, sys_rst = 1'b1, ref_sel_pin = 1'b0, parallel_pin = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cs_rate_valid = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] cs_rate_code = 4'h0;
  logic [31:0] s_axi_wdata = 32'h00000000, seed = 32'h00000030, rd, v;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic ext_frame_clk, ext_bit_clk, aux_data_in, rx_sync_pulse, rx_data, rx_prev;
  logic serial_data_out, master_clk_outputs, bit_clk, frame_clk, fc, bc, mc;
  logic pll_run, xtal_run, clk_src_xtal, tx_mclk_ext, tx_ext_clocks, unlock;
  logic wclk_en = 1'b0, drop = 1'b0, aux_val = 1'b1;
  int failures = 0, compares = 0, cyc = 0, n, nb, nm;

  acsm_top #(.LOCK_BASE_CYCLES(50), .WCLK_LOCK_CYCLES(80)) DUT (.clk, .sys_rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ref_sel_pin, .parallel_pin, .ext_frame_clk,
    .ext_bit_clk, .aux_data_in, .rx_sync_pulse, .rx_data, .cs_rate_code, .cs_rate_valid,
    .serial_data_out, .master_clk_outputs, .bit_clk, .frame_clk, .pll_run, .xtal_run,
    .clk_src_xtal, .tx_mclk_ext, .tx_ext_clocks, .unlock);

  acsm_src_model src (.clk, .period(14'(P)), .wclk_en, .drop, .aux_val, .ext_frame_clk,
    .ext_bit_clk, .aux_data_in, .rx_sync_pulse, .rx_data);

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) rx_prev <= rx_data;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      conclude();
    end
  end
  // ********************
  // Tasks
  // ********************
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdr(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // Expected {pll_run, xtal_run, crystal source, output kind: 0 rx, 1 aux, 2 low}
  function automatic logic [4:0] mexp(input logic [31:0] c, input logic lk);
    logic r, x;
    r = c[0] | ref_sel_pin;
    x = c[2] | (c[3] & ~lk);
    mexp[4] = c[3:2] != 2'h1;
    mexp[3] = !(c[9:8] == 2'h3 && c[3:2] == 2'h0);
    mexp[2] = x;
    mexp[1:0] = (!r && !x) ? 2'h0 : (c[4] && !r) ? 2'h2 : 2'h1;
  endfunction

  task automatic tmode(input logic [31:0] c, input logic lk);
    logic [4:0] e;
    logic as, so;
    logic [31:0] rn;
    e = mexp(c, lk);
    rn = xs();
    aux_val <= rn[0];
    as = c[4] & ~(c[0] | ref_sel_pin);
    wr(CT, c, 4'hF);
    repeat (24) @(posedge clk);
    `CHK("unlock", !lk, unlock);
    `CHK("pll_run", e[4], pll_run);
    `CHK("xtal_run", e[3], xtal_run);
    `CHK("clk_src_xtal", e[2], clk_src_xtal);
    `CHK("tx_ext_clocks", as, tx_ext_clocks);
    if (as) `CHK("tx_mclk_ext", c[5] | !e[3], tx_mclk_ext);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      so = (e[1:0] == 2'h0) ? rx_prev : (e[1:0] == 2'h1) ? aux_val : 1'b0;
      `CHK("serial_data_out", so, serial_data_out);
    end
  endtask

  task automatic glitch();
    drop <= 1'b1;
    repeat (1600) @(posedge clk);
    drop <= 1'b0;
    repeat (P + 10) @(posedge clk);
    `CHK("unlock_glitch", 1, unlock);
  endtask

  task automatic wlock();
    n = 0;
    while (unlock !== 1'b0 && n < 6 * P) begin
      @(posedge clk);
      n++;
    end
  endtask
  // ********************
  // Sequence
  // ********************
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdr(ST);
    `CHK("status_reset", 6'h0D, rd[5:0]);
    for (int i = 0; i < 4; i++) begin
      v = xs();
      wr(CT, v, 4'hF);
      rdr(CT);
      `CHK("ctrl_rd", v & 32'h0000037F, rd);
    end
    wr(4'h8, 32'hFFFFFFFF, 4'hF);
    `CHK("bad_bresp", acsm_pkg::AXI_SLVERR, rsp);
    rdr(4'hC);
    `CHK("bad_rresp", acsm_pkg::AXI_SLVERR, rsp);
    `CHK("bad_rdata", 32'h0, rd);
    wr(CT, 32'h00000000, 4'hF);
    glitch();
    repeat (12 * P) @(posedge clk);
    `CHK("unlock_slow", 1, unlock);
    parallel_pin <= 1'b1;
    glitch();
    wlock();
    `CHK("unlock_parallel", 0, unlock);
    parallel_pin <= 1'b0;
    rdr(ST);
    `CHK("rate_code", 4'h7, rd[10:7]);
    for (int i = 8; i >= 0; i--) begin
      tmode({22'h0, 10'(i == 8 ? 10'h312 : i == 7 ? 10'h302 : i == 6 ? 10'h03E :
        10'(4'h2 + 4'h4 * (i % 4) - 4'h4 * (i % 4 == 1)) | (i > 2 ? 10'h10 : 10'h0))}, 1);
    end
    drop <= 1'b1;
    repeat (6000) @(posedge clk);
    rdr(ST);
    `CHK("loss_seen", 1, rd[16]);
    wr(ST, 32'h00010000, 4'h4);
    rdr(ST);
    `CHK("loss_clear", 0, rd[16]);
    tmode(32'h0A, 0);
    tmode(32'h1A, 0);
    tmode(32'h16, 0);
    tmode(32'h306, 0);
    drop <= 1'b0;
    wclk_en <= 1'b1;
    ref_sel_pin <= 1'b1;
    // Word clock not synchronous to any stream, so its sync bit stays clear
    wr(CT, 32'h02, 4'hF);
    wlock();
    `CHK("unlock_wclk", 0, unlock);
    tmode(32'h02, 1);
    fc = frame_clk;
    bc = bit_clk;
    mc = master_clk_outputs;
    n = 0;
    nb = 0;
    nm = 0;
    repeat (2 * P) begin
      @(posedge clk);
      n = n + (frame_clk !== fc);
      nb = nb + (bit_clk !== bc);
      nm = nm + (master_clk_outputs !== mc);
      fc = frame_clk;
      bc = bit_clk;
      mc = master_clk_outputs;
    end
    `CHK("frame_clk_moves", 1, n > 1);
    `CHK("bit_clk_faster", 1, nb > 16 * n);
    `CHK("mclk_faster", 1, nm > 2 * nb);
    drop <= 1'b1;
    repeat (6000) @(posedge clk);
    tmode(32'h0A, 0);
    tmode(32'h06, 0);
    drop <= 1'b0;
    ref_sel_pin <= 1'b0;
    wr(CT, 32'h03, 4'hF);
    wlock();
    rdr(ST);
    `CHK("eff_ref_reg", 2'h2, rd[1:0]);
    tmode(32'h03, 1);
    cs_rate_code <= 4'(xs() % 10);
    cs_rate_valid <= 1'b1;
    wr(CT, 32'h300, 4'hF);
    repeat (4) @(posedge clk);
    rdr(ST);
    `CHK("cs_rate", {cs_rate_code, 1'b1}, rd[10:6]);
    conclude();
  end
endmodule
